// File: rtl/undervoltage_reset_filter.sv
// Digital side of the supply monitor: cycle filter, reset hold and status flag.
//
// Function
// - Monitor active straight out of reset.
// - Comparator ignored unless power option set.
// - Reset after nine consecutive low CPU cycles.
// - Hold reset until one cycle above rising.
// - Status flag follows comparator, not reset path.
// - Undervoltage reset also drives reset pin low.
// - Reset option clear: never reset, poll only.
// - Flag sets after 32 to 40 crystal cycles.
// - rst_i or supply above rising clears the status flag, not undervoltage reset.
// - Monitor raises no interrupt request.
// - Monitoring continues in wait mode.
// - Qualified trip in wait resets device.
// - Stop option: trip bypasses filter in stop.
// - Stop option clear: inactive in stop.
// - Options are fixed inputs, not writable.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
module undervoltage_reset_filter #(
    parameter int FILTER_CYCLES = uv_filter_pkg::FILTER_CYCLES,
    parameter int FLAG_QUAL_CYCLES = uv_filter_pkg::FLAG_QUAL_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Analogue comparator outputs, asynchronous
    input wire logic below_falling_trip_i,
    input wire logic above_rising_trip_i,
    // Factory options, fixed at manufacture
    input wire logic monitor_power_option_i,
    input wire logic undervolt_reset_option_i,
    input wire logic monitor_in_stop_option_i,
    // Clock enables and low-power state
    input wire logic cpu_cycle_en_i,
    input wire logic crystal_clock_en_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    // Reset and interrupt outputs
    output logic undervolt_reset_o,
    output logic reset_pin_n_o,
    output logic reset_pin_oe_o,
    output logic irq_o,
    // Avalon-MM slave
    input wire logic [1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o
);
    initial begin
        if (FILTER_CYCLES < 1 || FILTER_CYCLES > 63) begin
            $error("FILTER_CYCLES out of range");
        end
        if (FLAG_QUAL_CYCLES < uv_filter_pkg::FLAG_MIN_CYCLES ||
            FLAG_QUAL_CYCLES > uv_filter_pkg::FLAG_MAX_CYCLES) begin
            $error("FLAG_QUAL_CYCLES outside the allowed window");
        end
    end

    // Comparator outputs are asynchronous; only the second stage is read.
    logic below_s1_ff;
    logic below_s2_ff;
    logic above_s1_ff;
    logic above_s2_ff;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            below_s1_ff <= 1'b0;
            below_s2_ff <= 1'b0;
            above_s1_ff <= 1'b1;
            above_s2_ff <= 1'b1;
        end else begin
            below_s1_ff <= below_falling_trip_i;
            below_s2_ff <= below_s1_ff;
            above_s1_ff <= above_rising_trip_i;
            above_s2_ff <= above_s1_ff;
        end
    end

    // The monitor needs no software enable; the options and stop mode gate it.
    logic monitor_active;
    assign monitor_active = monitor_power_option_i
        && (!stop_mode_i || monitor_in_stop_option_i);

    logic below_valid;
    assign below_valid = monitor_active && below_s2_ff;

    // CPU cycle filter; stop mode halts the CPU clock so the filter is bypassed there.
    logic filter_done;
    logic [5:0] filter_count;

    uv_qualify_counter #(
        .LIMIT(FILTER_CYCLES),
        .WIDTH(6)
    ) u_filter (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(cpu_cycle_en_i && !stop_mode_i),
        .level_i(below_valid),
        .done_o(filter_done),
        .count_o(filter_count)
    );

    logic trip;
    assign trip = undervolt_reset_option_i
        && (filter_done || (stop_mode_i && below_valid));

    // Reset hold state machine.
    uv_filter_pkg::uv_state_t state_ff;
    uv_filter_pkg::uv_state_t nxt_state;

    always_comb begin
        case (state_ff)
            uv_filter_pkg::ST_IDLE: begin
                if (trip) begin
                    nxt_state = uv_filter_pkg::ST_HOLD;
                end else if (below_valid) begin
                    nxt_state = uv_filter_pkg::ST_COUNT;
                end else begin
                    nxt_state = uv_filter_pkg::ST_IDLE;
                end
            end
            uv_filter_pkg::ST_COUNT: begin
                if (trip) begin
                    nxt_state = uv_filter_pkg::ST_HOLD;
                end else if (!below_valid) begin
                    nxt_state = uv_filter_pkg::ST_IDLE;
                end else begin
                    nxt_state = uv_filter_pkg::ST_COUNT;
                end
            end
            uv_filter_pkg::ST_HOLD: begin
                // One CPU cycle above the rising level releases the hold.
                if (above_s2_ff && cpu_cycle_en_i) begin
                    nxt_state = uv_filter_pkg::ST_IDLE;
                end else begin
                    nxt_state = uv_filter_pkg::ST_HOLD;
                end
            end
            default: nxt_state = uv_filter_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= uv_filter_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    logic reset_ff;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reset_ff <= 1'b0;
        end else begin
            reset_ff <= (nxt_state == uv_filter_pkg::ST_HOLD);
        end
    end

    assign undervolt_reset_o = reset_ff;
    // Open-drain pin: drive low only while the hold is on.
    assign reset_pin_n_o = 1'b0;
    assign reset_pin_oe_o = reset_ff;
    assign irq_o = 1'b0;

    // Status flag, qualified on crystal clock enables from the synchronised, option-gated comparator (below_valid).
    logic flag_done;
    logic flag_ff;

    uv_qualify_counter #(
        .LIMIT(FLAG_QUAL_CYCLES),
        .WIDTH(6)
    ) u_flag_qual (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(crystal_clock_en_i),
        .level_i(below_valid),
        .done_o(flag_done),
        .count_o()
    );

    // Between the two levels the flag keeps its value; set wins over release.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flag_ff <= 1'b0;
        end else if (flag_done) begin
            flag_ff <= 1'b1;
        end else if (above_s2_ff) begin
            flag_ff <= 1'b0;
        end
    end

    logic [7:0] status_w;
    logic [7:0] options_w;
    always_comb begin
        status_w = uv_filter_pkg::STATUS_RESET;
        status_w[uv_filter_pkg::FLAG_BIT] = flag_ff;
        status_w[uv_filter_pkg::RST_BIT] = reset_ff;
        status_w[uv_filter_pkg::WAIT_BIT] = wait_mode_i;
        status_w[uv_filter_pkg::STOP_BIT] = stop_mode_i;
        options_w = 8'h00;
        options_w[uv_filter_pkg::OPT_PWR_BIT] = monitor_power_option_i;
        options_w[uv_filter_pkg::OPT_RST_BIT] = undervolt_reset_option_i;
        options_w[uv_filter_pkg::OPT_STOP_BIT] = monitor_in_stop_option_i;
    end

    // Registers are read-only so the options can never be changed by software.
    uv_avalon_slave u_bus (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .address_i(address_i),
        .read_i(read_i),
        .write_i(write_i),
        .writedata_i(writedata_i),
        .byteenable_i(byteenable_i),
        .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o),
        .status_i(status_w),
        .options_i(options_w),
        .counter_i({2'b00, filter_count})
    );

    // Checks.
    no_reset_opt_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !undervolt_reset_option_i |-> !undervolt_reset_o)
        else $error("reset raised with reset option clear");
    filter_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ($rose(undervolt_reset_o) && !$past(stop_mode_i)) |->
        $past(filter_count) == 6'(FILTER_CYCLES))
        else $error("reset before filter completed");
    no_power_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !monitor_power_option_i |=> !$rose(undervolt_reset_o))
        else $error("reset with monitor unpowered");
    release_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (undervolt_reset_o && above_s2_ff && cpu_cycle_en_i) |=> !undervolt_reset_o)
        else $error("reset not released");
    pin_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
        reset_pin_oe_o == undervolt_reset_o && !reset_pin_n_o)
        else $error("reset pin not following");
    stop_bypass_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (stop_mode_i && below_valid && undervolt_reset_option_i) |=> undervolt_reset_o)
        else $error("stop trip did not reset");
    stop_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (stop_mode_i && !monitor_in_stop_option_i && !undervolt_reset_o)
        |=> !undervolt_reset_o)
        else $error("reset in stop with stop option clear");
    flag_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (above_s2_ff && !flag_done) |=> !flag_ff)
        else $error("flag not cleared above rising level");
    no_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !irq_o)
        else $error("interrupt raised");
    cov_reset_c: cover property (@(posedge clock_i) disable iff (rst_i)
        $rose(undervolt_reset_o));
    cov_flag_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(flag_ff));
    cov_stop_c: cover property (@(posedge clock_i) disable iff (rst_i)
        stop_mode_i && $rose(undervolt_reset_o));
endmodule // undervoltage_reset_filter

// File: rtl/uv_avalon_slave.sv
// Avalon-MM slave giving read access to the undervoltage monitor registers.
`timescale 1ns/1ps
module uv_avalon_slave (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Avalon-MM
    input wire logic [1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Register contents
    input wire logic [7:0] status_i,
    input wire logic [7:0] options_i,
    input wire logic [7:0] counter_i
);
    logic ack_ff;
    logic [31:0] nxt_readdata;
    logic [31:0] readdata_ff;

    // Every access takes one wait cycle; the data is registered in that cycle.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (read_i || write_i) && !ack_ff;
        end
    end

    always_comb begin
        case (address_i)
            uv_filter_pkg::ADDR_STATUS: nxt_readdata = {24'h00_0000, status_i};
            uv_filter_pkg::ADDR_OPTIONS: nxt_readdata = {24'h00_0000, options_i};
            uv_filter_pkg::ADDR_COUNTER: nxt_readdata = {24'h00_0000, counter_i};
            default: nxt_readdata = uv_filter_pkg::READ_UNMAPPED;
        endcase
    end

    // All registers are read-only; writes complete and are discarded.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_ff <= 32'h0000_0000;
        end else if (read_i && !ack_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    assign readdata_o = readdata_ff;
    assign waitrequest_o = (read_i || write_i) && !ack_ff;

    logic unused_w;
    assign unused_w = ^{writedata_i, byteenable_i};
endmodule // uv_avalon_slave

// File: rtl/uv_filter_pkg.sv
// Shared constants for the undervoltage reset filter.
package uv_filter_pkg;
    // Register map, word addresses on the Avalon-MM slave (byte address / 4).
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_OPTIONS = 2'h1;
    localparam logic [1:0] ADDR_COUNTER = 2'h2;
    // Field positions in the status register.
    localparam int FLAG_BIT = 0;
    localparam int RST_BIT = 1;
    localparam int WAIT_BIT = 2;
    localparam int STOP_BIT = 3;
    // Field positions in the options readback register.
    localparam int OPT_PWR_BIT = 0;
    localparam int OPT_RST_BIT = 1;
    localparam int OPT_STOP_BIT = 2;
    // Filter and flag qualification figures, in cycles.
    localparam int FILTER_CYCLES = 9;
    localparam int FLAG_MIN_CYCLES = 32;
    localparam int FLAG_MAX_CYCLES = 40;
    localparam int FLAG_QUAL_CYCLES = 36;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_HOLD = 2'b10
    } uv_state_t;
endpackage

// File: rtl/uv_qualify_counter.sv
// Saturating run-length counter that qualifies a level held for a number of enabled cycles.
`timescale 1ns/1ps
module uv_qualify_counter #(
    parameter int LIMIT = 9,
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Level to qualify
    input wire logic enable_i,
    input wire logic level_i,
    // Result
    output logic done_o,
    output logic [WIDTH-1:0] count_o
);
    logic [WIDTH-1:0] count_ff;

    initial begin
        if (LIMIT < 1 || LIMIT >= (1 << WIDTH)) begin
            $error("uv_qualify_counter: LIMIT does not fit WIDTH");
        end
    end

    // A gap in the level restarts the run so that noise cannot accumulate.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else if (!level_i) begin
            count_ff <= '0;
        end else if (enable_i && count_ff != WIDTH'(LIMIT)) begin
            count_ff <= count_ff + WIDTH'(1);
        end
    end

    assign done_o = (count_ff == WIDTH'(LIMIT));
    assign count_o = count_ff;
endmodule // uv_qualify_counter

// File: verification/supply_model.sv
// Behavioural supply comparator with CPU and crystal clock enable sources.
`timescale 1ns/1ps
module supply_model (
    // Clock
    input wire logic clock_i,
    // Commanded supply: 0 above rising level, 1 between levels, 2 below falling level
    input wire logic [1:0] level_i,
    input wire logic cpu_run_i,
    input wire logic [2:0] cpu_div_i,
    // Comparator outputs and enables
    output logic below_o,
    output logic above_o,
    output logic cpu_en_o,
    output logic xtal_en_o
);
    logic [2:0] cpu_cnt_ff = 3'h0;
    logic [1:0] xtal_cnt_ff = 2'h0;
    // The two comparator outputs are never high together, as on the real divider.
    assign below_o = (level_i == 2'h2);
    assign above_o = (level_i == 2'h0);
    // CPU enables stop while the processor clocks are halted in stop mode.
    assign cpu_en_o = cpu_run_i && (cpu_cnt_ff == 3'h0);
    assign xtal_en_o = (xtal_cnt_ff == 2'h0);
    always_ff @(posedge clock_i) begin
        cpu_cnt_ff <= (cpu_cnt_ff + 3'h1 >= cpu_div_i) ? 3'h0 : cpu_cnt_ff + 3'h1;
        xtal_cnt_ff <= xtal_cnt_ff + 2'h1;
    end
endmodule // supply_model

// File: verification/undervoltage_reset_filter_tb.sv
// Self-checking bench for the undervoltage reset filter.
`timescale 1ns/1ps
module undervoltage_reset_filter_tb;
    logic clock_i = 1'h0;
    logic rst_i = 1'h1;
    logic [1:0] level = 2'h0;
    logic cpu_run = 1'h1;
    logic [2:0] cpu_div = 3'h2;
    logic pwr = 1'h1, rst_opt = 1'h1, stp = 1'h0, wait_m = 1'h0, stop_m = 1'h0;
    logic below, above, cpu_en, xtal_en, uv_rst, pin_n, pin_oe, irq, waitreq;
    logic [1:0] address = 2'h0;
    logic read = 1'h0, write = 1'h0, seen = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, d;
    int n_errors = 0;
    int comparisons = 0;

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (uv_rst === 1'h1) seen <= 1'h1;

    supply_model supply_model_i (.clock_i(clock_i), .level_i(level), .cpu_run_i(cpu_run),
        .cpu_div_i(cpu_div), .below_o(below), .above_o(above), .cpu_en_o(cpu_en),
        .xtal_en_o(xtal_en));
    undervoltage_reset_filter undervoltage_reset_filter_i (.clock_i(clock_i), .rst_i(rst_i),
        .below_falling_trip_i(below), .above_rising_trip_i(above),
        .monitor_power_option_i(pwr), .undervolt_reset_option_i(rst_opt),
        .monitor_in_stop_option_i(stp), .cpu_cycle_en_i(cpu_en), .crystal_clock_en_i(xtal_en),
        .wait_mode_i(wait_m), .stop_mode_i(stop_m), .undervolt_reset_o(uv_rst),
        .reset_pin_n_o(pin_n), .reset_pin_oe_o(pin_oe), .irq_o(irq), .address_i(address),
        .read_i(read), .write_i(write), .writedata_i(wdata), .byteenable_i(4'hf),
        .readdata_o(rdata), .waitrequest_o(waitreq));

    task automatic finish_test();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check1(input logic e, input logic a);
        comparisons++;
        if (a !== e) begin
            n_errors++;
            $display("MISMATCH %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic check32(input logic [31:0] e, input logic [31:0] a);
        comparisons++;
        if (a !== e) begin
            n_errors++;
            $display("MISMATCH %0t exp %h got %h", $time, e, a);
        end
    endtask
    function automatic logic [31:0] exp_opts(input logic p, input logic r, input logic s);
        exp_opts = 32'h0000_0000;
        exp_opts[uv_filter_pkg::OPT_PWR_BIT] = p;
        exp_opts[uv_filter_pkg::OPT_RST_BIT] = r;
        exp_opts[uv_filter_pkg::OPT_STOP_BIT] = s;
    endfunction
    task automatic timeout();
        n_errors++;
        finish_test();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Counts enable pulses; a stuck enable source ends the run instead of hanging it.
    task automatic wait_en(input bit xtal, input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge clock_i);
                k++;
            end while (!(xtal ? xtal_en : cpu_en) && k < 20);
            if (k >= 20) timeout();
        end
    endtask
    task automatic wait_rst(input logic e, input int bound);
        int k;
        k = 0;
        while (uv_rst !== e && k < bound) begin
            @(posedge clock_i);
            k++;
        end
        check1(e, uv_rst);
        check1(e, pin_oe);
        check1(1'h0, pin_n);
        check1(1'h0, irq);
    endtask
    // One request, held until the edge that samples waitrequest low.
    // Waitrequest is looked at once it has settled after an edge, so the value seen is the one
    // that the next rising edge samples; the request is released only after that edge.
    task automatic bus(input logic we, input logic [1:0] a, input logic [31:0] w);
        int k;
        @(posedge clock_i);
        address <= a;
        wdata <= w;
        read <= !we;
        write <= we;
        k = 0;
        #1;
        while (waitreq !== 1'h0 && k < 20) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        if (k >= 20) timeout();
        @(posedge clock_i);
        d = rdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic do_reset(input logic p, input logic r, input logic s);
        pwr <= p;
        rst_opt <= r;
        stp <= s;
        rst_i <= 1'h1;
        tick(4);
        rst_i <= 1'h0;
        seen <= 1'h0;
    endtask

    initial begin
        void'($urandom(32'h59d8));
        do_reset(1'h1, 1'h1, 1'h0);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check32({24'h00_0000, uv_filter_pkg::STATUS_RESET}, d);
        bus(1'h1, uv_filter_pkg::ADDR_OPTIONS, 32'hffff_ffff);
        bus(1'h0, uv_filter_pkg::ADDR_OPTIONS, 32'h0000_0000);
        check32(exp_opts(1'h1, 1'h1, 1'h0), d);
        bus(1'h0, 2'h3, 32'h0000_0000);
        check32(uv_filter_pkg::READ_UNMAPPED, d);
        bus(1'h0, uv_filter_pkg::ADDR_COUNTER, 32'h0000_0000);
        check32(32'h0000_0000, d);
        // Short dips separated by recoveries must never add up to a trip.
        for (int t = 0; t < 4; t++) begin
            cpu_div <= 3'(2 + $urandom % 3);
            level <= 2'h2;
            wait_en(1'b0, 1 + $urandom % 7);
            level <= 2'h1;
            tick(6);
            check1(1'h0, uv_rst);
        end
        level <= 2'h2;
        wait_en(1'b0, 8);
        check1(1'h0, uv_rst);
        wait_rst(1'h1, 20);
        level <= 2'h1;
        tick(20);
        check1(1'h1, uv_rst);
        level <= 2'h0;
        tick(3);
        wait_en(1'b0, 1);
        level <= 2'h1;
        wait_rst(1'h0, 6);
        do_reset(1'h1, 1'h0, 1'h0);
        level <= 2'h2;
        wait_en(1'b1, 30);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check1(1'h0, d[uv_filter_pkg::FLAG_BIT]);
        wait_en(1'b1, 13);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check1(1'h1, d[uv_filter_pkg::FLAG_BIT]);
        level <= 2'h1;
        tick(40);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check1(1'h1, d[uv_filter_pkg::FLAG_BIT]);
        check1(1'h0, seen);
        do_reset(1'h1, 1'h0, 1'h0);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check1(1'h0, d[uv_filter_pkg::FLAG_BIT]);
        level <= 2'h2;
        wait_en(1'b1, 45);
        level <= 2'h0;
        tick(4);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check1(1'h0, d[uv_filter_pkg::FLAG_BIT]);
        do_reset(1'h0, 1'h1, 1'h0);
        level <= 2'h2;
        wait_en(1'b1, 45);
        bus(1'h0, uv_filter_pkg::ADDR_STATUS, 32'h0000_0000);
        check1(1'h0, d[uv_filter_pkg::FLAG_BIT]);
        check1(1'h0, seen);
        level <= 2'h0;
        do_reset(1'h1, 1'h1, 1'h0);
        wait_m <= 1'h1;
        level <= 2'h2;
        wait_rst(1'h1, 60);
        wait_m <= 1'h0;
        level <= 2'h0;
        wait_rst(1'h0, 20);
        do_reset(1'h1, 1'h1, 1'h1);
        stop_m <= 1'h1;
        cpu_run <= 1'h0;
        level <= 2'h2;
        wait_rst(1'h1, 6);
        level <= 2'h0;
        stop_m <= 1'h0;
        cpu_run <= 1'h1;
        wait_rst(1'h0, 20);
        do_reset(1'h1, 1'h1, 1'h0);
        stop_m <= 1'h1;
        level <= 2'h2;
        tick(60);
        check1(1'h0, seen);
        finish_test();
    end
endmodule // undervoltage_reset_filter_tb
